// File: rat_defs.svh
// Purpose: register offsets, field positions and timing figures
// Assumes: byte-wide register port, 1 Hz calendar advance strobe
// Notes:   times are in their own units; second counts derive in the code
`ifndef RAT_DEFS_SVH
`define RAT_DEFS_SVH

// register offsets
`define RAT_OFF_STATUS       8'h07
`define RAT_OFF_INT_CTRL     8'h08
`define RAT_OFF_SUPPLY_CTRL  8'h09
`define RAT_OFF_TEMP_CTRL    8'h0d
`define RAT_OFF_FINAL_ATRIM  8'h0e
`define RAT_OFF_FINAL_DTRIM  8'h0f
`define RAT_OFF_ALARM_BASE   8'h10
`define RAT_OFF_ALARM_LAST   8'h15
`define RAT_OFF_STAMP_BASE   8'h16
`define RAT_OFF_STAMP_LAST   8'h1a

// field positions
`define RAT_BIT_ALARM_FLAG   6
`define RAT_BIT_AUTO_CLEAR   7
`define RAT_BIT_PULSED_SEL   6
`define RAT_BIT_STAMP_CLEAR  7
`define RAT_BIT_TSE          7
`define RAT_BIT_BATTERY_TEMP_SENSE_ENABLE         6
`define RAT_BIT_BATTERY_SENSE_RATE_SELECT         5
`define RAT_BIT_ALARM_EN     7

// reset values
`define RAT_RST_BYTE         8'h00
`define RAT_RST_ALARM_BYTE   8'h01
`define RAT_RST_GAIN         4'h8

// gain factor legal range
`define RAT_GAIN_MIN         4'h4
`define RAT_GAIN_MAX         4'hc

// timing: sensing periods in minutes, alarm pulse width in cycles
`define RAT_BATT_SLOW_MIN    10
`define RAT_BATT_FAST_MIN    1
`define RAT_MAINS_MIN        1
`define RAT_SEC_PER_MIN      60
`define RAT_IRQ_PULSE_CYCLES 4'h8

`endif

// File: rat_pkg.sv
// Purpose: shared types of the alarm, trim and time stamp block
// Assumes: nothing beyond rat_defs.svh
// Notes:   alarm mode is a resolved state, not a register field
package rat_pkg;

    typedef enum logic [1:0] {
        ALM_OFF    = 2'b00,
        ALM_SINGLE = 2'b01,
        ALM_PULSED = 2'b10
    } rat_alarm_mode_t;

    typedef logic [7:0] rat_byte_t;

endpackage

// File: rat_top.sv
// Purpose: temp sensing schedule, trim gain, final trims, alarm, stamp
// Assumes: cal_advance pulses with the already advanced calendar bytes
// Notes:   register port answers reads one cycle after the strobe
`include "rat_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module rat_top (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    input  wire logic                   cal_advance,
    input  wire logic [7:0]             cal_seconds,
    input  wire logic [7:0]             cal_minutes,
    input  wire logic [7:0]             cal_hours,
    input  wire logic [7:0]             cal_date,
    input  wire logic [7:0]             cal_month,
    input  wire logic [7:0]             cal_weekday,
    input  wire logic                   battery_mode,
    input  wire logic                   vbat_low,
    input  wire logic                   freq_out_active,
    input  wire logic [5:0]             init_analog_trim,
    input  wire logic [2:0]             init_digital_trim,
    input  wire logic                   corr_done,
    input  wire logic [5:0]             corr_analog_trim,
    input  wire logic [2:0]             corr_digital_trim,
    output logic                        sense_start,
    output logic      [3:0]             gain_applied,
    output logic                        gain_valid,
    output logic      [5:0]             final_analog_trim,
    output logic      [2:0]             final_digital_trim,
    output logic signed [8:0]           digital_trim_ppm,
    output rat_pkg::rat_alarm_mode_t    alarm_mode,
    output logic                        irq_n
);
    import rat_pkg::*;

    localparam logic [9:0] SLOW_SEC =
        10'(`RAT_BATT_SLOW_MIN * `RAT_SEC_PER_MIN);
    localparam logic [9:0] FAST_SEC =
        10'(`RAT_BATT_FAST_MIN * `RAT_SEC_PER_MIN);
    localparam logic [9:0] MAINS_SEC =
        10'(`RAT_MAINS_MIN * `RAT_SEC_PER_MIN);

    logic            tse_q, battery_temp_sense_enable_q, battery_sense_rate_select_q, auto_clear_q, pulsed_sel_q;
    logic [3:0]      gain_q;
    logic [3:0]      gain_applied_q;
    logic [5:0]      fatrim_q;
    logic [2:0]      fdtrim_q;
    logic signed [8:0] ppm_q;
    rat_byte_t       alarm_q [6];
    rat_byte_t       stamp_q [5];
    rat_byte_t       cal_now [6];
    logic            stamp_armed_q, batt_prev_q;
    logic            alarm_flag_q, match_prev_q;
    logic [3:0]      pulse_cnt_q;
    logic [9:0]      sec_cnt_q, period_sec;
    logic            sense_en, sense_start_q;
    logic            match_now, any_en, alarm_fire, capture;
    logic            wr_status, wr_stamp_clr, rd_status;
    rat_byte_t       rd_mux, rdata_q;
    rat_alarm_mode_t mode;

    assign cal_now = '{cal_seconds, cal_minutes, cal_hours,
                       cal_date, cal_month, cal_weekday};

    assign wr_status    = reg_wr && reg_addr == `RAT_OFF_STATUS;
    assign rd_status    = reg_rd && reg_addr == `RAT_OFF_STATUS;
    assign wr_stamp_clr = reg_wr && reg_addr == `RAT_OFF_SUPPLY_CTRL
                          && reg_wdata[`RAT_BIT_STAMP_CLEAR];

    // control bits; trim status offsets take no write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tse_q        <= 1'b0;
            battery_temp_sense_enable_q       <= 1'b0;
            battery_sense_rate_select_q       <= 1'b0;
            gain_q       <= `RAT_RST_GAIN;
            auto_clear_q <= 1'b0;
            pulsed_sel_q <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `RAT_OFF_TEMP_CTRL: begin
                    tse_q  <= reg_wdata[`RAT_BIT_TSE];
                    battery_temp_sense_enable_q <= reg_wdata[`RAT_BIT_BATTERY_TEMP_SENSE_ENABLE];
                    battery_sense_rate_select_q <= reg_wdata[`RAT_BIT_BATTERY_SENSE_RATE_SELECT];
                    gain_q <= reg_wdata[3:0];
                end
                `RAT_OFF_INT_CTRL: begin
                    auto_clear_q <= reg_wdata[`RAT_BIT_AUTO_CLEAR];
                    pulsed_sel_q <= reg_wdata[`RAT_BIT_PULSED_SEL];
                end
                default: ;
            endcase
        end
    end

    // alarm bytes keep the calendar layout with enable on top
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++)
                alarm_q[i] <= `RAT_RST_ALARM_BYTE;
        end else if (reg_wr && reg_addr >= `RAT_OFF_ALARM_BASE
                     && reg_addr <= `RAT_OFF_ALARM_LAST) begin
            alarm_q[3'(reg_addr - `RAT_OFF_ALARM_BASE)] <= reg_wdata;
        end
    end

    // sensing schedule counted in calendar seconds
    always_comb begin
        if (battery_mode)
            period_sec = battery_sense_rate_select_q ? FAST_SEC : SLOW_SEC;
        else
            period_sec = MAINS_SEC;
    end

    assign sense_en = tse_q && (!battery_mode || (battery_temp_sense_enable_q && !vbat_low));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sec_cnt_q     <= 10'h000;
            sense_start_q <= 1'b0;
        end else begin
            sense_start_q <= 1'b0;
            if (!sense_en) begin
                sec_cnt_q <= 10'h000;
            end else if (cal_advance) begin
                if (sec_cnt_q >= period_sec - 10'h001) begin
                    sec_cnt_q     <= 10'h000;
                    sense_start_q <= 1'b1;
                end else begin
                    sec_cnt_q <= sec_cnt_q + 10'h001;
                end
            end
        end
    end

    // gain is taken only at a sensing start, so a half-written gain
    // under sense disabled never reaches the trim engine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            gain_applied_q <= `RAT_RST_GAIN;
        else if (sense_start_q)
            gain_applied_q <= gain_q;
    end

    // step multiplier is code/8: 4 gives 0.500, 8 unity, 12 gives 1.500
    assign gain_valid = gain_applied_q >= `RAT_GAIN_MIN
                        && gain_applied_q <= `RAT_GAIN_MAX;

    function automatic logic signed [8:0] dtrim_ppm(input logic [2:0] c);
        case (c)
            3'h6:    dtrim_ppm = 9'sd196;
            3'h7:    dtrim_ppm = -9'sd32;
            default: dtrim_ppm = 9'($unsigned(c) * 32);
        endcase
    endfunction

    // final trims follow the initial values while sensing is off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fatrim_q <= 6'h00;
            fdtrim_q <= 3'h0;
            ppm_q    <= 9'sh000;
        end else if (!tse_q) begin
            fatrim_q <= init_analog_trim;
            fdtrim_q <= init_digital_trim;
            ppm_q    <= dtrim_ppm(init_digital_trim);
        end else if (corr_done) begin
            fatrim_q <= corr_analog_trim;
            fdtrim_q <= corr_digital_trim;
            ppm_q    <= dtrim_ppm(corr_digital_trim);
        end
    end

    // alarm compare over the low seven bits of enabled fields
    always_comb begin
        any_en    = 1'b0;
        match_now = 1'b1;
        for (int i = 0; i < 6; i++) begin
            if (alarm_q[i][`RAT_BIT_ALARM_EN]) begin
                any_en = 1'b1;
                if (alarm_q[i][6:0] != cal_now[i][6:0])
                    match_now = 1'b0;
            end
        end
        match_now = match_now && any_en;
    end

    // edge of the match so a minute-wide match fires only once
    assign alarm_fire = cal_advance && match_now && !match_prev_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            match_prev_q <= 1'b0;
        else if (cal_advance)
            match_prev_q <= match_now;
    end

    always_comb begin
        if (!any_en || freq_out_active)
            mode = ALM_OFF;
        else if (pulsed_sel_q)
            mode = ALM_PULSED;
        else
            mode = ALM_SINGLE;
    end

    // set wins over both write clear and auto-clear read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            alarm_flag_q <= 1'b0;
        else if (alarm_fire)
            alarm_flag_q <= 1'b1;
        else if (wr_status && !reg_wdata[`RAT_BIT_ALARM_FLAG])
            alarm_flag_q <= 1'b0;
        else if (rd_status && auto_clear_q)
            alarm_flag_q <= 1'b0;
    end

    // pulse width independent of the flag, so pulses never stall
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            pulse_cnt_q <= 4'h0;
        else if (alarm_fire && mode == ALM_PULSED)
            pulse_cnt_q <= `RAT_IRQ_PULSE_CYCLES;
        else if (pulse_cnt_q != 4'h0)
            pulse_cnt_q <= pulse_cnt_q - 4'h1;
    end

    always_comb begin
        case (mode)
            ALM_SINGLE: irq_n = !alarm_flag_q;
            ALM_PULSED: irq_n = pulse_cnt_q == 4'h0;
            default:    irq_n = 1'b1;
        endcase
    end

    // first switchover only; capture beats a clear in the same cycle
    assign capture = battery_mode && !batt_prev_q && stamp_armed_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            batt_prev_q   <= 1'b0;
            stamp_armed_q <= 1'b1;
            for (int i = 0; i < 5; i++)
                stamp_q[i] <= `RAT_RST_BYTE;
        end else begin
            batt_prev_q <= battery_mode;
            if (capture) begin
                stamp_armed_q <= 1'b0;
                for (int i = 0; i < 5; i++)
                    stamp_q[i] <= cal_now[i];
            end else if (wr_stamp_clr) begin
                stamp_armed_q <= 1'b1;
                for (int i = 0; i < 5; i++)
                    stamp_q[i] <= `RAT_RST_BYTE;
            end
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `RAT_OFF_STATUS:
                rd_mux[`RAT_BIT_ALARM_FLAG] = alarm_flag_q;
            `RAT_OFF_INT_CTRL: begin
                rd_mux[`RAT_BIT_AUTO_CLEAR] = auto_clear_q;
                rd_mux[`RAT_BIT_PULSED_SEL] = pulsed_sel_q;
            end
            `RAT_OFF_TEMP_CTRL:
                rd_mux = {tse_q, battery_temp_sense_enable_q, battery_sense_rate_select_q, 1'b0, gain_q};
            `RAT_OFF_FINAL_ATRIM: rd_mux = {2'b00, fatrim_q};
            `RAT_OFF_FINAL_DTRIM: rd_mux = {5'h00, fdtrim_q};
            default: begin
                if (reg_addr >= `RAT_OFF_ALARM_BASE
                    && reg_addr <= `RAT_OFF_ALARM_LAST)
                    rd_mux = alarm_q[3'(reg_addr - `RAT_OFF_ALARM_BASE)];
                else if (reg_addr >= `RAT_OFF_STAMP_BASE
                         && reg_addr <= `RAT_OFF_STAMP_LAST)
                    rd_mux = stamp_q[3'(reg_addr - `RAT_OFF_STAMP_BASE)];
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rd_mux;
    end

    assign reg_rdata          = rdata_q;
    assign sense_start        = sense_start_q;
    assign gain_applied       = gain_applied_q;
    assign final_analog_trim  = fatrim_q;
    assign final_digital_trim = fdtrim_q;
    assign digital_trim_ppm   = ppm_q;
    assign alarm_mode         = mode;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence fire_pulsed_s;
        alarm_fire && mode == ALM_PULSED;
    endsequence
    // a mode change away from pulsed ends the pulse legitimately
    sequence irq_low8_s;
        (!irq_n || mode != ALM_PULSED) [*8];
    endsequence

    AST_BATT_SLOW_PERIOD: assert property (
        sense_start_q && battery_mode && !battery_sense_rate_select_q |->
            $past(sec_cnt_q) == SLOW_SEC - 10'h001)
        else $error("slow battery sensing period wrong");
    AST_BATT_SENSE_OFF: assert property (
        battery_mode && !battery_temp_sense_enable_q |=> !sense_start_q)
        else $error("battery sensing ran with enable off");
    AST_VBAT_LOW_OFF: assert property (
        battery_mode && vbat_low |=> !sense_start_q)
        else $error("battery sensing ran at low battery");
    AST_GAIN_NEXT_CYCLE: assert property (
        sense_start_q |=> gain_applied_q == $past(gain_q))
        else $error("gain not applied at sensing start");
    AST_TRIM_INIT: assert property (
        !tse_q ##1 !tse_q |-> fatrim_q == $past(init_analog_trim))
        else $error("analog trim not initial while sensing off");
    AST_DTRIM_RO: assert property (
        reg_wr && reg_addr == `RAT_OFF_FINAL_DTRIM && tse_q
        && !corr_done |=> $stable(fdtrim_q))
        else $error("digital trim changed by write");
    AST_SINGLE_HOLD: assert property (
        alarm_fire && mode == ALM_SINGLE ##1 mode == ALM_SINGLE
        |-> !irq_n && alarm_flag_q)
        else $error("single alarm did not assert interrupt");
    AST_PULSE_WIDTH: assert property (
        fire_pulsed_s |=> irq_low8_s
        ##1 (irq_n || mode != ALM_PULSED || $past(alarm_fire)))
        else $error("alarm pulse width wrong");
    AST_FLAG_ON_FIRE: assert property (
        alarm_fire |=> alarm_flag_q)
        else $error("alarm flag not set on trigger");
    AST_AUTO_CLEAR: assert property (
        rd_status && auto_clear_q && !alarm_fire |=> !alarm_flag_q)
        else $error("auto-clear read left flag set");
    AST_FIRE_ONCE: assert property (
        alarm_fire |=> !alarm_fire throughout (!cal_advance)[*1])
        else $error("alarm fired twice");
    AST_STAMP_FIRST: assert property (
        !stamp_armed_q && !wr_stamp_clr |=> $stable(stamp_q[0]))
        else $error("stamp updated on later switchover");
    AST_STAMP_CLEAR: assert property (
        wr_stamp_clr && !capture |=> stamp_armed_q
        && stamp_q[4] == `RAT_RST_BYTE && stamp_q[3] == `RAT_RST_BYTE)
        else $error("stamp clear did not zero and re-arm");

endmodule // rat_top

`default_nettype wire

// File: rat_host.sv
// Purpose: host side of the byte register port
// Assumes: one-cycle strobes, read data valid the cycle after the strobe
// Notes:   every change lands just after a rising edge
`timescale 1ns/1ns
`default_nettype none

module rat_host (
    input  wire logic       mclk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  <= 8'h00;
        reg_wdata <= 8'h00;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // gain goes in with sensing off first, then again with the control bits of ctl
    task automatic write_gain(input logic [3:0] g, input logic [7:0] ctl);
        write_reg(8'h0d, {ctl[7:4] & 4'h7, g});
        write_reg(8'h0d, {ctl[7:4], g});
    endtask
endmodule // rat_host

`default_nettype wire

// File: rat_top_bench.sv
// Purpose: self-checking bench for the alarm, trim and stamp block
// Assumes: host model owns the register port
// Notes:   calendar, supply and correction inputs change at rising edges
`timescale 1ns/1ns
`default_nettype none

module rat_top_bench;
    import rat_pkg::*;

    logic                  mclk;
    logic                  rst;
    logic                  cal_advance;
    logic                  battery_mode;
    logic                  vbat_low;
    logic                  freq_out_active;
    logic                  corr_done;
    logic            [7:0] cal [6];
    logic            [5:0] init_analog_trim;
    logic            [5:0] corr_analog_trim;
    logic            [2:0] init_digital_trim;
    logic            [2:0] corr_digital_trim;
    logic            [7:0] reg_addr;
    logic            [7:0] reg_wdata;
    logic            [7:0] reg_rdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic                  sense_start;
    logic            [3:0] gain_applied;
    logic                  gain_valid;
    logic            [5:0] final_analog_trim;
    logic            [2:0] final_digital_trim;
    logic signed     [8:0] digital_trim_ppm;
    rat_alarm_mode_t       alarm_mode;
    logic                  irq_n;
    logic            [7:0] st [5];
    logic            [7:0] m;
    logic            [3:0] g;
    int                    fail_count;
    int                    comparisons;
    int                    pulses;
    int                    lows;
    logic            [7:0] ctl [5] = '{8'he0, 8'hc0, 8'ha0, 8'he0, 8'h60};
    int                    per [5] = '{60, 600, 0, 0, 0};
    logic                  vb [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

    rat_host i_host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    rat_top i_dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cal_advance(cal_advance),
        .cal_seconds(cal[0]), .cal_minutes(cal[1]), .cal_hours(cal[2]),
        .cal_date(cal[3]), .cal_month(cal[4]), .cal_weekday(cal[5]),
        .battery_mode(battery_mode), .vbat_low(vbat_low),
        .freq_out_active(freq_out_active),
        .init_analog_trim(init_analog_trim),
        .init_digital_trim(init_digital_trim), .corr_done(corr_done),
        .corr_analog_trim(corr_analog_trim),
        .corr_digital_trim(corr_digital_trim),
        .sense_start(sense_start), .gain_applied(gain_applied),
        .gain_valid(gain_valid), .final_analog_trim(final_analog_trim),
        .final_digital_trim(final_digital_trim),
        .digital_trim_ppm(digital_trim_ppm), .alarm_mode(alarm_mode),
        .irq_n(irq_n)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (sense_start === 1'b1)
            pulses++;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic compare(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read_reg(a, d);
        compare({1'b0, d}, {1'b0, exp});
    endtask

    function automatic logic [8:0] ppm_of(input logic [2:0] c);
        if (c == 3'd7)
            return 9'h1e0;
        if (c == 3'd6)
            return 9'd196;
        return 9'(c) * 9'd32;
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic advance(input int n);
        repeat (n) begin
            @(posedge mclk);
            cal_advance <= 1'b1;
            @(posedge mclk);
            cal_advance <= 1'b0;
        end
        #1;
    endtask

    // minutes forced, the rest random with the top bit clear
    task automatic set_cal(input logic [7:0] mv);
        @(posedge mclk);
        foreach (cal[k])
            cal[k] <= (k == 1) ? mv : 8'($urandom_range(8'h59, 8'h01));
    endtask

    // one non-matching advance first so the match is a fresh arrival
    task automatic hit(input logic [7:0] mv);
        set_cal(mv ^ 8'h01);
        advance(1);
        set_cal(mv);
        advance(1);
    endtask

    task automatic chk_stamp;
        for (int k = 0; k < 5; k++)
            rd_cmp(8'h16 + 8'(k), st[k]);
    endtask

    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'ha44d));
        rst = 1'b1;
        cal_advance = 1'b0;
        battery_mode = 1'b0;
        vbat_low = 1'b0;
        freq_out_active = 1'b0;
        corr_done = 1'b0;
        foreach (cal[k]) cal[k] = 8'h01;
        init_analog_trim = 6'($urandom);
        init_digital_trim = 3'($urandom);
        corr_analog_trim = 6'h00;
        corr_digital_trim = 3'h0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        compare(9'(gain_applied), 9'h008);
        compare(9'(irq_n), 9'h001);
        rd_cmp(8'h10, 8'h01);
        for (int k = 0; k < 5; k++) st[k] = 8'h00;
        chk_stamp();
        rd_cmp(8'h0e, {2'b00, init_analog_trim});
        rd_cmp(8'h0f, {5'b00000, init_digital_trim});
        $display("test reset done");

        set_cal(8'h12);
        battery_mode <= 1'b1;
        #1 st = cal[0:4];
        chk_stamp();
        @(posedge mclk) battery_mode <= 1'b0;
        set_cal(8'h34);
        battery_mode <= 1'b1;
        chk_stamp();
        i_host.write_reg(8'h09, 8'h80);
        for (int k = 0; k < 5; k++) st[k] = 8'h00;
        chk_stamp();
        @(posedge mclk) battery_mode <= 1'b0;
        set_cal(8'h21);
        battery_mode <= 1'b1;
        #1 st = cal[0:4];
        chk_stamp();
        $display("test stamp done");

        m = 8'($urandom_range(8'h59, 8'h00));
        i_host.write_reg(8'h11, 8'h80 | m);
        freq_out_active <= 1'b1;
        hit(m);
        compare(9'(irq_n), 9'h001);
        rd_cmp(8'h07, 8'h40);
        i_host.write_reg(8'h07, 8'h00);
        freq_out_active <= 1'b0;
        #1 compare(9'(alarm_mode), 9'(ALM_SINGLE));
        set_cal(m ^ 8'h01);
        advance(1);
        compare(9'(irq_n), 9'h001);
        set_cal(m);
        advance(1);
        compare(9'(irq_n), 9'h000);
        set_cal(m ^ 8'h02);
        advance(1);
        compare(9'(irq_n), 9'h000);
        i_host.write_reg(8'h07, 8'h40);
        #1 compare(9'(irq_n), 9'h000);
        i_host.write_reg(8'h07, 8'h00);
        #1 compare(9'(irq_n), 9'h001);
        i_host.write_reg(8'h08, 8'h80);
        hit(m);
        rd_cmp(8'h07, 8'h40);
        rd_cmp(8'h07, 8'h00);
        compare(9'(irq_n), 9'h001);
        // match still standing at the next advance must not refire
        advance(1);
        compare(9'(irq_n), 9'h001);
        $display("test single alarm done");

        i_host.write_reg(8'h08, 8'h40);
        #1 compare(9'(alarm_mode), 9'(ALM_PULSED));
        repeat (2) begin
            hit(m);
            lows = 0;
            repeat (12) begin
                if (irq_n === 1'b0)
                    lows++;
                wait_cyc(1);
            end
            compare(9'(lows), 9'd8);
        end
        rd_cmp(8'h07, 8'h40);
        i_host.write_reg(8'h11, 8'h00);
        #1 compare(9'(alarm_mode), 9'(ALM_OFF));
        $display("test pulsed alarm done");

        g = 4'(4 + $urandom_range(8));
        for (int i = 0; i < 5; i++) begin
            i_host.write_gain(g, ctl[i]);
            vbat_low <= vb[i];
            pulses = 0;
            if (per[i] != 0) begin
                advance(per[i] - 1);
                wait_cyc(2);
                compare(9'(pulses), 9'd0);
                advance(1);
                wait_cyc(2);
                compare(9'(pulses), 9'd1);
                compare(9'(gain_applied), 9'(g));
                compare(9'(gain_valid), 9'h001);
            end else begin
                advance(120);
                wait_cyc(2);
                compare(9'(pulses), 9'd0);
            end
        end
        $display("test sensing done");

        i_host.write_gain(g, 8'h80);
        for (int c = 0; c < 8; c++) begin
            @(posedge mclk);
            corr_analog_trim  <= 6'($urandom);
            corr_digital_trim <= 3'(c);
            corr_done         <= 1'b1;
            @(posedge mclk);
            corr_done <= 1'b0;
            wait_cyc(2);
            compare(digital_trim_ppm, ppm_of(3'(c)));
            i_host.write_reg(8'h0e, 8'hff);
            i_host.write_reg(8'h0f, ~8'(c));
            rd_cmp(8'h0e, {2'b00, corr_analog_trim});
            rd_cmp(8'h0f, {5'b00000, 3'(c)});
        end
        i_host.write_reg(8'h0d, {4'h0, g});
        init_analog_trim  <= 6'($urandom);
        init_digital_trim <= 3'($urandom);
        wait_cyc(3);
        compare(9'(final_analog_trim), 9'(init_analog_trim));
        compare(9'(final_digital_trim), 9'(init_digital_trim));
        $display("test trims done");
        tally_and_finish();
    end
endmodule // rat_top_bench

`default_nettype wire
